// *** beam_scan_pkg.sv ***
package beam_scan_pkg;
  localparam int NP = 288;
  localparam int IDX_W = 9;
  localparam int NUM_W = 10;
  localparam int AREAS = 32;
  localparam int IO_W = 8;
  localparam logic [IDX_W-1:0] LAST_ELEM = 9'h11f;
  localparam logic [NUM_W-1:0] NP_NUM = 10'h120;
  localparam logic [1:0] MODE_PARALLEL = 2'h0;
  localparam logic [1:0] MODE_DIAGONAL = 2'h1;
  localparam logic [1:0] MODE_CROSSED = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_CAP = 2'b10,
    ST_DONE = 2'b11
  } scan_state_t;
endpackage

// *** beam_scan_evaluation.sv ***
`timescale 1ns/1ps
`default_nettype none
module beam_scan_evaluation
  import beam_scan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic scan_start,
  input wire logic [1:0] beam_mode,
  input wire logic reverse_count,
  output logic [IDX_W-1:0] tx_sel_r,
  output logic [IDX_W-1:0] rx_sel_r,
  output logic sample_req_r,
  input wire logic rx_light,
  output logic beam_valid_r,
  output logic beam_bit_r,
  output logic [NUM_W-1:0] beam_num_r,
  output logic beam_last_r,
  input wire logic beam_ready,
  input wire logic [AREAS*NUM_W-1:0] area_lo,
  input wire logic [AREAS*NUM_W-1:0] area_hi,
  input wire logic [IO_W-1:0] io_pins,
  output logic busy_r,
  output logic result_valid_r,
  output logic [NUM_W-1:0] first_blocked_beam,
  output logic [NUM_W-1:0] last_blocked_beam,
  output logic [NUM_W-1:0] first_clear_beam,
  output logic [NUM_W-1:0] last_clear_beam,
  output logic [NUM_W-1:0] count_blocked_beams,
  output logic [NUM_W-1:0] count_clear_beams,
  output logic [AREAS-1:0] area_blocked_r,
  output logic [IO_W-1:0] io_state_r
);

  function automatic logic [IDX_W-1:0] phys(input logic [IDX_W-1:0] idx, input logic rev);
    phys = rev ? LAST_ELEM - idx : idx;
  endfunction

  function automatic logic [1:0] phases(input logic [IDX_W-1:0] idx, input logic [1:0] mode);
    if (idx == '0) begin
      phases = 2'h1;
    end else if (mode == MODE_DIAGONAL) begin
      phases = 2'h2;
    end else if (mode == MODE_CROSSED) begin
      phases = 2'h3;
    end else begin
      phases = 2'h1;
    end
  endfunction

  function automatic logic [NUM_W-1:0] beam_total(input logic [1:0] mode);
    if (mode == MODE_DIAGONAL) begin
      beam_total = NUM_W'(2 * NP - 1);
    end else if (mode == MODE_CROSSED) begin
      beam_total = NUM_W'(3 * NP - 2);
    end else begin
      beam_total = NP_NUM;
    end
  endfunction

  // Scan sequencer
  scan_state_t st_r, st_nxt;
  logic [IDX_W-1:0] elem_r, elem_nxt, tx_nxt, rx_nxt, l_tx, l_rx;
  logic [1:0] ph_r, ph_nxt, mode_r, mode_nxt;
  logic rev_r, rev_nxt, req_nxt, busy_nxt;
  logic [NUM_W-1:0] num_r, num_nxt;
  logic push, push_last, skid_v_r;

  always_comb begin
    st_nxt = st_r;
    elem_nxt = elem_r;
    ph_nxt = ph_r;
    mode_nxt = mode_r;
    rev_nxt = rev_r;
    num_nxt = num_r;
    tx_nxt = tx_sel_r;
    rx_nxt = rx_sel_r;
    req_nxt = 1'b0;
    busy_nxt = busy_r;
    push = 1'b0;
    push_last = (elem_r == LAST_ELEM) && (ph_r == phases(elem_r, mode_r) - 2'h1);
    // Inclined paths first, parallel last, so numbers rise along the field
    l_tx = elem_r;
    l_rx = elem_r;
    if (ph_r != phases(elem_r, mode_r) - 2'h1) begin
      if (ph_r == 2'h0) begin
        l_rx = elem_r - 9'h001;
      end else begin
        l_tx = elem_r - 9'h001;
      end
    end
    case (st_r)
      ST_IDLE: begin
        if (scan_start) begin
          mode_nxt = beam_mode;
          rev_nxt = reverse_count;
          elem_nxt = '0;
          ph_nxt = 2'h0;
          num_nxt = '0;
          busy_nxt = 1'b1;
          st_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        // Only sample while the buffer has room, so no light result is dropped
        if (!skid_v_r) begin
          req_nxt = 1'b1;
          tx_nxt = phys(l_tx, rev_r);
          rx_nxt = phys(l_rx, rev_r);
          num_nxt = num_r + 10'h001;
          st_nxt = ST_CAP;
        end
      end
      ST_CAP: begin
        push = 1'b1;
        if (push_last) begin
          st_nxt = ST_DONE;
        end else begin
          st_nxt = ST_REQ;
          if (ph_r == phases(elem_r, mode_r) - 2'h1) begin
            elem_nxt = elem_r + 9'h001;
            ph_nxt = 2'h0;
          end else begin
            ph_nxt = ph_r + 2'h1;
          end
        end
      end
      ST_DONE: begin
        busy_nxt = 1'b0;
        st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      elem_r <= '0;
      ph_r <= 2'h0;
      mode_r <= MODE_PARALLEL;
      rev_r <= 1'b0;
      num_r <= '0;
      tx_sel_r <= '0;
      rx_sel_r <= '0;
      sample_req_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      elem_r <= elem_nxt;
      ph_r <= ph_nxt;
      mode_r <= mode_nxt;
      rev_r <= rev_nxt;
      num_r <= num_nxt;
      tx_sel_r <= tx_nxt;
      rx_sel_r <= rx_nxt;
      sample_req_r <= req_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Two-entry stream buffer: output stage plus skid entry
  logic out_v_nxt, out_bit_nxt, out_last_nxt, skid_v_nxt, skid_bit_r, skid_bit_nxt, skid_last_r, skid_last_nxt;
  logic [NUM_W-1:0] out_num_nxt, skid_num_r, skid_num_nxt;
  logic pop;

  always_comb begin
    pop = beam_valid_r && beam_ready;
    out_v_nxt = beam_valid_r;
    out_bit_nxt = beam_bit_r;
    out_num_nxt = beam_num_r;
    out_last_nxt = beam_last_r;
    skid_v_nxt = skid_v_r;
    skid_bit_nxt = skid_bit_r;
    skid_num_nxt = skid_num_r;
    skid_last_nxt = skid_last_r;
    if (pop && skid_v_r) begin
      out_bit_nxt = skid_bit_r;
      out_num_nxt = skid_num_r;
      out_last_nxt = skid_last_r;
      skid_v_nxt = push;
      skid_bit_nxt = rx_light;
      skid_num_nxt = num_r;
      skid_last_nxt = push_last;
    end else if (pop || !beam_valid_r) begin
      out_v_nxt = push;
      out_bit_nxt = rx_light;
      out_num_nxt = num_r;
      out_last_nxt = push_last;
    end else if (push) begin
      skid_v_nxt = 1'b1;
      skid_bit_nxt = rx_light;
      skid_num_nxt = num_r;
      skid_last_nxt = push_last;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      beam_valid_r <= 1'b0;
      beam_bit_r <= 1'b0;
      beam_num_r <= '0;
      beam_last_r <= 1'b0;
      skid_v_r <= 1'b0;
      skid_bit_r <= 1'b0;
      skid_num_r <= '0;
      skid_last_r <= 1'b0;
    end else begin
      beam_valid_r <= out_v_nxt;
      beam_bit_r <= out_bit_nxt;
      beam_num_r <= out_num_nxt;
      beam_last_r <= out_last_nxt;
      skid_v_r <= skid_v_nxt;
      skid_bit_r <= skid_bit_nxt;
      skid_num_r <= skid_num_nxt;
      skid_last_r <= skid_last_nxt;
    end
  end

  // Evaluation; zero means no such beam in this scan
  logic [NUM_W-1:0] fb_r, lb_r, fc_r, lc_r, cb_r, cc_r;
  logic [NUM_W-1:0] fb_nxt, lb_nxt, fc_nxt, lc_nxt, cb_nxt, cc_nxt;
  logic [AREAS-1:0] acc_area_r, acc_area_nxt, area_out_nxt;
  logic [NUM_W-1:0] fbo_nxt, lbo_nxt, fco_nxt, lco_nxt, cbo_nxt, cco_nxt;
  logic [IO_W-1:0] io_nxt;
  logic res_v_nxt;

  always_comb begin
    fb_nxt = fb_r;
    lb_nxt = lb_r;
    fc_nxt = fc_r;
    lc_nxt = lc_r;
    cb_nxt = cb_r;
    cc_nxt = cc_r;
    acc_area_nxt = acc_area_r;
    fbo_nxt = first_blocked_beam;
    lbo_nxt = last_blocked_beam;
    fco_nxt = first_clear_beam;
    lco_nxt = last_clear_beam;
    cbo_nxt = count_blocked_beams;
    cco_nxt = count_clear_beams;
    area_out_nxt = area_blocked_r;
    io_nxt = io_state_r;
    res_v_nxt = 1'b0;
    if (st_r == ST_IDLE && scan_start) begin
      fb_nxt = '0;
      lb_nxt = '0;
      fc_nxt = '0;
      lc_nxt = '0;
      cb_nxt = '0;
      cc_nxt = '0;
      acc_area_nxt = '0;
    end else if (st_r == ST_CAP) begin
      if (!rx_light) begin
        if (fb_r == '0) begin
          fb_nxt = num_r;
        end
        lb_nxt = num_r;
        cb_nxt = cb_r + 10'h001;
      end else begin
        if (fc_r == '0) begin
          fc_nxt = num_r;
        end
        lc_nxt = num_r;
        cc_nxt = cc_r + 10'h001;
      end
      for (int a = 0; a < AREAS; a++) begin
        // An area with start beam 0 is unused
        if (!rx_light && area_lo[a*NUM_W +: NUM_W] != '0 && num_r >= area_lo[a*NUM_W +: NUM_W]
            && num_r <= area_hi[a*NUM_W +: NUM_W]) begin
          acc_area_nxt[a] = 1'b1;
        end
      end
    end else if (st_r == ST_DONE) begin
      fbo_nxt = fb_r;
      lbo_nxt = lb_r;
      fco_nxt = fc_r;
      lco_nxt = lc_r;
      cbo_nxt = cb_r;
      cco_nxt = cc_r;
      area_out_nxt = acc_area_r;
      io_nxt = io_pins;
      res_v_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fb_r <= '0;
      lb_r <= '0;
      fc_r <= '0;
      lc_r <= '0;
      cb_r <= '0;
      cc_r <= '0;
      acc_area_r <= '0;
      first_blocked_beam <= '0;
      last_blocked_beam <= '0;
      first_clear_beam <= '0;
      last_clear_beam <= '0;
      count_blocked_beams <= '0;
      count_clear_beams <= '0;
      area_blocked_r <= '0;
      io_state_r <= '0;
      result_valid_r <= 1'b0;
    end else begin
      fb_r <= fb_nxt;
      lb_r <= lb_nxt;
      fc_r <= fc_nxt;
      lc_r <= lc_nxt;
      cb_r <= cb_nxt;
      cc_r <= cc_nxt;
      acc_area_r <= acc_area_nxt;
      first_blocked_beam <= fbo_nxt;
      last_blocked_beam <= lbo_nxt;
      first_clear_beam <= fco_nxt;
      last_clear_beam <= lco_nxt;
      count_blocked_beams <= cbo_nxt;
      count_clear_beams <= cco_nxt;
      area_blocked_r <= area_out_nxt;
      io_state_r <= io_nxt;
      result_valid_r <= res_v_nxt;
    end
  end

  a_parallel_facing: assert property (@(posedge sys_clk) disable iff (!rstn)
    sample_req_r && mode_r == MODE_PARALLEL |-> tx_sel_r == rx_sel_r)
    else $error("parallel beam not facing");
  a_diag_neighbour: assert property (@(posedge sys_clk) disable iff (!rstn)
    sample_req_r && mode_r == MODE_DIAGONAL && tx_sel_r != rx_sel_r
    |-> (rev_r ? rx_sel_r == tx_sel_r + 9'h001 : rx_sel_r == tx_sel_r - 9'h001))
    else $error("diagonal receiver not at i-1");
  a_cross_adjacent: assert property (@(posedge sys_clk) disable iff (!rstn)
    sample_req_r && mode_r == MODE_CROSSED
    |-> tx_sel_r == rx_sel_r || tx_sel_r == rx_sel_r + 9'h001 || rx_sel_r == tx_sel_r + 9'h001)
    else $error("crossed receiver not adjacent");
  a_total_count: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_r == ST_DONE |-> cb_r + cc_r == beam_total(mode_r) && num_r == beam_total(mode_r))
    else $error("logical beam total wrong");
  a_stream_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_r == ST_CAP && !beam_valid_r |=> beam_valid_r && beam_bit_r == $past(rx_light) && beam_num_r == $past(num_r))
    else $error("stream bit does not match sample");
  a_stream_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    beam_valid_r && !beam_ready |=> beam_valid_r && $stable(beam_num_r) && $stable(beam_bit_r))
    else $error("stream word lost under stall");
  a_number_rises: assert property (@(posedge sys_clk) disable iff (!rstn)
    sample_req_r |-> num_r == $past(num_r) + 10'h001)
    else $error("beam number does not rise by one");
  a_first_number: assert property (@(posedge sys_clk) disable iff (!rstn)
    st_r == ST_IDLE && scan_start ##1 st_r == ST_REQ && !skid_v_r |=> num_r == 10'h001
    && tx_sel_r == (rev_r ? LAST_ELEM : 9'h000))
    else $error("beam 1 at wrong end");
  a_results_order: assert property (@(posedge sys_clk) disable iff (!rstn)
    result_valid_r |-> first_blocked_beam <= last_blocked_beam && first_clear_beam <= last_clear_beam
    && $past(io_pins) == io_state_r)
    else $error("evaluation results inconsistent");

endmodule
`default_nettype wire

// *** optic_front.sv ***
`timescale 1ns/1ps
`default_nettype none
module optic_front
  import beam_scan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [IDX_W-1:0] tx_sel_r,
  input wire logic [IDX_W-1:0] rx_sel_r,
  input wire logic sample_req_r,
  input wire logic [1:0] mode,
  input wire logic rev,
  output logic rx_light
);
  logic q[$];
  int bad = 0;
  int first_tx = -1;
  int d;
  logic free;
  initial rx_light = 1'b0;
  // Object shadows transmitters 10..20 on every path
  // Answer at the falling edge so the level stands at the capturing rising edge
  always @(negedge sys_clk) begin
    d = int'(rx_sel_r) - int'(tx_sel_r);
    free = !(tx_sel_r >= 9'h00a && tx_sel_r <= 9'h014);
    if (sample_req_r === 1'b1) begin
      if (q.size() == 0)
        first_tx = int'(tx_sel_r);
      if (mode == MODE_PARALLEL && d != 0) bad++;
      if (mode == MODE_DIAGONAL && d != 0 && d != (rev ? 1 : -1)) bad++;
      if (mode == MODE_CROSSED && (d > 1 || d < -1)) bad++;
      q.push_back(free);
      rx_light <= free;
    end else begin
      // Only valid for one cycle; toggling exposes late sampling
      rx_light <= !rx_light;
    end
  end
endmodule
`default_nettype wire

// *** beam_scan_evaluation_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module beam_scan_evaluation_bench;
  import beam_scan_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, scan_start = 1'b0, reverse_count = 1'b0;
  logic beam_ready = 1'b0, rx_light;
  logic [1:0] beam_mode = 2'h0;
  logic [AREAS*NUM_W-1:0] area_lo = '0, area_hi = '0;
  logic [IO_W-1:0] io_pins = 8'ha5;
  logic [IDX_W-1:0] tx_sel_r, rx_sel_r;
  logic sample_req_r, beam_valid_r, beam_bit_r, beam_last_r, busy_r, result_valid_r;
  logic [NUM_W-1:0] beam_num_r, fbb, lbb, fcb, lcb, nbb, ncb;
  logic [AREAS-1:0] area_blocked_r;
  logic [IO_W-1:0] io_state_r;
  int errors = 0;
  int check_count = 0;

  always #5 sys_clk = ~sys_clk;

  beam_scan_evaluation uut (.sys_clk(sys_clk), .rstn(rstn), .scan_start(scan_start),
    .beam_mode(beam_mode), .reverse_count(reverse_count), .tx_sel_r(tx_sel_r),
    .rx_sel_r(rx_sel_r), .sample_req_r(sample_req_r), .rx_light(rx_light),
    .beam_valid_r(beam_valid_r), .beam_bit_r(beam_bit_r), .beam_num_r(beam_num_r),
    .beam_last_r(beam_last_r), .beam_ready(beam_ready), .area_lo(area_lo),
    .area_hi(area_hi), .io_pins(io_pins), .busy_r(busy_r), .result_valid_r(result_valid_r),
    .first_blocked_beam(fbb), .last_blocked_beam(lbb), .first_clear_beam(fcb),
    .last_clear_beam(lcb), .count_blocked_beams(nbb), .count_clear_beams(ncb),
    .area_blocked_r(area_blocked_r), .io_state_r(io_state_r));

  optic_front optic (.sys_clk(sys_clk), .tx_sel_r(tx_sel_r), .rx_sel_r(rx_sel_r),
    .sample_req_r(sample_req_r), .mode(beam_mode), .rev(reverse_count), .rx_light(rx_light));

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One scan with a stalling sink and a refused start in mid-scan
  task automatic run_scan(input logic [1:0] m, input logic r, input int n, input string tname);
    int k, t, fb, lb, fc, lc, nb;
    logic got, ab;
    k = 0;
    t = 0;
    got = 1'b0;
    optic.q.delete();
    optic.first_tx = -1;
    @(posedge sys_clk);
    beam_mode <= m;
    reverse_count <= r;
    io_pins <= {6'h15, m};
    scan_start <= 1'b1;
    @(posedge sys_clk);
    scan_start <= 1'b0;
    while ((k < n || !got) && t < 20000) begin
      @(negedge sys_clk);
      t++;
      if (result_valid_r === 1'b1)
        got = 1'b1;
      if ((beam_valid_r & beam_ready) === 1'b1) begin
        k++;
        check("beam_num", beam_num_r, k);
        check("beam_bit", beam_bit_r, optic.q[k-1]);
        check("beam_last", beam_last_r, k == n);
      end
      @(posedge sys_clk);
      beam_ready <= !(t % 3 == 0 || (t > 30 && t < 60));
      scan_start <= (t == 7);
    end
    if (k != n || !got) begin
      errors++;
      test_done();
    end
    fb = 0;
    lb = 0;
    fc = 0;
    lc = 0;
    nb = 0;
    ab = 1'b0;
    foreach (optic.q[j]) begin
      if (optic.q[j]) begin
        if (fc == 0) fc = j + 1;
        lc = j + 1;
      end else begin
        if (fb == 0) fb = j + 1;
        lb = j + 1;
        nb++;
        if (j < 40) ab = 1'b1;
      end
    end
    check("sample_count", optic.q.size(), n);
    check("pairing", optic.bad, 0);
    check("first_tx", optic.first_tx, r ? int'(LAST_ELEM) : 0);
    check("first_blocked", fbb, fb);
    check("last_blocked", lbb, lb);
    check("first_clear", fcb, fc);
    check("last_clear", lcb, lc);
    check("count_blocked", nbb, nb);
    check("count_clear", ncb, n - nb);
    check("areas", area_blocked_r, {31'h0, ab});
    check("io_state", io_state_r, {6'h15, m});
    repeat (3) @(negedge sys_clk);
    check("idle_after", busy_r, 1'b0);
    $display("test %s done", tname);
  endtask

  initial begin
    area_lo[NUM_W-1:0] = 10'h001;
    area_hi[NUM_W-1:0] = 10'h028;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    run_scan(MODE_PARALLEL, 1'b0, NP, "parallel");
    run_scan(MODE_DIAGONAL, 1'b0, 2 * NP - 1, "diagonal");
    run_scan(MODE_CROSSED, 1'b1, 3 * NP - 2, "crossed_reversed");
    run_scan(MODE_DIAGONAL, 1'b1, 2 * NP - 1, "diagonal_reversed");
    run_scan(MODE_CROSSED, 1'b0, 3 * NP - 2, "crossed");
    test_done();
  end
endmodule
`default_nettype wire
